// ---- src/bmc_pkg.sv ----
// Package for the buffer manager control register block
package bmc_pkg;
  // Register offsets on the multiplexed processor bus
  localparam logic [7:0] OFS_HOST_CTL = 8'h52;
  localparam logic [7:0] OFS_XFER_CTL = 8'h53;
  localparam logic [7:0] OFS_BUF_SIZE = 8'h54;
  localparam logic [7:0] OFS_ADDR_MODE = 8'h55;
  localparam logic [7:0] OFS_RESET_CTL = 8'h59;
  localparam logic [7:0] OFS_RD_PTR_LO = 8'h5A;
  localparam logic [7:0] OFS_RD_PTR_HI = 8'h5B;
  localparam logic [7:0] OFS_WR_PTR_LO = 8'h5C;
  localparam logic [7:0] OFS_WR_PTR_HI = 8'h5D;
  localparam logic [7:0] OFS_STOP_LO = 8'h5E;
  localparam logic [7:0] OFS_STOP_HI = 8'h5F;
  // Host interface control bit positions
  localparam int HC_ARB = 0;
  localparam int HC_IN_EN = 2;
  localparam int HC_OUT_EN = 3;
  localparam int HC_SEL_IN = 4;
  localparam int HC_BSY_IN = 5;
  localparam int HC_SEL_OUT = 6;
  localparam int HC_BSY_OUT = 7;
  // Transfer control bit positions
  localparam int XC_ACK = 1;
  localparam int XC_H2B = 2;
  localparam int XC_B2H = 3;
  localparam int XC_DIR = 4;
  localparam int XC_DONE = 5;
  localparam int XC_INIT = 6;
  localparam int XC_TGT = 7;
  // Reset values and pointer width
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam int PTR_W = 16;
  localparam int FIFO_DEPTH = 32;
  // Processor bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bmc_req_s;
  // Host handshake state
  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_REQ = 3'b010,
    HS_ACKW = 3'b100
  } bmc_hs_e;
endpackage

// ---- src/bmc_top.sv ----
// Buffer manager control registers, host DMA handshake and disk byte FIFO
`timescale 1ns/1ps
// How it works
// - Bit0 write enables arbitration, read gives status
// - Inbound bit drives host inbound enable
// - Outbound bit drives host outbound enable
// - Select and busy inputs read live
// - Busy out bit drives busy pin
// - Transfer bit1 reads the ACK pin
// - Host-to-buffer start needs direction cleared
// - Buffer-to-host start needs direction set
// - Direction picks byte strobe data direction
// - Done set when stop equals active pointer
// - Bits 6,7 drive active-low enable outputs
// - Extended mode drives upper address lines
// - Reset bit holds registers; pin sets it
// - Reset register write clears all pointers
// - Pointers 16 bits as low/high bytes
// - Write pointer steps per disk byte in
// - Read pointer steps per host handshake with direction set
// - Unused bits read undefined, here zero
// - Compare masked by buffer size
// - Stop pointer write clears done, resumes
module bmc_top #(
  parameter int DATA_W = 8,
  parameter int DEPTH = bmc_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Processor register port
  input wire bmc_pkg::bmc_req_s cpu_req,
  output logic [7:0] cpu_rdata,
  // SCSI status and control pins
  input wire logic scsi_sel_in,
  input wire logic scsi_bsy_in,
  input wire logic scsi_ack_in,
  input wire logic arb_status,
  output logic arb_enable,
  output logic scsi_sel_out,
  output logic scsi_bsy_out,
  output logic host_inbound_enable,
  output logic host_outbound_enable,
  output logic initiator_enable_out_n,
  output logic target_enable_out_n,
  output logic host_req,
  // Buffer addressing
  output logic [3:0] upper_direct_address_lines,
  output logic upper_addr_en,
  output logic [15:0] buf_addr,
  // Disk byte stream
  input wire logic disk_byte_strobe,
  input wire logic [DATA_W-1:0] disk_in_data,
  output logic disk_in_ready,
  output logic [DATA_W-1:0] disk_out_data,
  output logic disk_out_valid,
  // Buffer side of the disk FIFO
  output logic [DATA_W-1:0] buf_wdata,
  output logic buf_wvalid,
  input wire logic buf_wready
);
  logic [7:0] host_ctl_reg, host_ctl_next;
  logic [7:0] xfer_ctl_reg, xfer_ctl_next;
  logic [7:0] buf_size_reg, buf_size_next;
  logic [7:0] addr_mode_reg, addr_mode_next;
  logic reset_bit_reg, reset_bit_next;
  logic [15:0] rd_ptr_reg, rd_ptr_next;
  logic [15:0] wr_ptr_reg, wr_ptr_next;
  logic [15:0] stop_reg, stop_next;
  logic [7:0] rdata_reg, rdata_next;
  bmc_pkg::bmc_hs_e hs_reg, hs_next;
  logic [15:0] mask, active_ptr;
  logic done, dma_on, disk_in_take, host_step, hold, wr_hit;

  // Buffer size widens the compare window in powers of two above one page
  assign mask = {buf_size_reg, 8'hFF};
  assign active_ptr = xfer_ctl_reg[bmc_pkg::XC_DIR] ? rd_ptr_reg : wr_ptr_reg;
  assign done = ((stop_reg ^ active_ptr) & mask) == 16'h0000;
  // host-to-buffer runs only with direction clear
  // buffer-to-host runs only with direction set
  assign dma_on = !done && (xfer_ctl_reg[bmc_pkg::XC_DIR]
                  ? xfer_ctl_reg[bmc_pkg::XC_B2H] : xfer_ctl_reg[bmc_pkg::XC_H2B]);
  assign hold = !rst_n || reset_bit_reg;
  assign wr_hit = cpu_req.wr && !hold;
  // Inbound disk bytes accepted on the strobe when direction is set
  // strobe direction from the direction bit
  assign disk_in_take = disk_byte_strobe && xfer_ctl_reg[bmc_pkg::XC_DIR] && disk_in_ready;
  // Host handshake ends when the host releases its acknowledge
  assign host_step = (hs_reg == bmc_pkg::HS_ACKW) && !scsi_ack_in;

  // Host request and acknowledge sequencer
  always_comb
  begin
    hs_next = hs_reg;
    case (hs_reg)
      bmc_pkg::HS_IDLE:
        if (dma_on)
          hs_next = bmc_pkg::HS_REQ;
      bmc_pkg::HS_REQ:
        if (scsi_ack_in)
          hs_next = bmc_pkg::HS_ACKW;
      bmc_pkg::HS_ACKW:
        if (!scsi_ack_in)
          hs_next = bmc_pkg::HS_IDLE;
      default: hs_next = bmc_pkg::HS_IDLE;
    endcase
  end

  // Register writes and pointer motion
  always_comb
  begin
    host_ctl_next = host_ctl_reg;
    xfer_ctl_next = xfer_ctl_reg;
    buf_size_next = buf_size_reg;
    addr_mode_next = addr_mode_reg;
    reset_bit_next = reset_bit_reg;
    rd_ptr_next = rd_ptr_reg;
    wr_ptr_next = wr_ptr_reg;
    stop_next = stop_reg;
    if (disk_in_take)
      wr_ptr_next = wr_ptr_reg + 16'h0001;
    // Host-to-buffer bytes also land at the write pointer
    if (host_step && !xfer_ctl_reg[bmc_pkg::XC_DIR])
      wr_ptr_next = wr_ptr_reg + 16'h0001;
    if (host_step && xfer_ctl_reg[bmc_pkg::XC_DIR])
      rd_ptr_next = rd_ptr_reg + 16'h0001;
    if (cpu_req.wr)
    begin
      if (cpu_req.addr == bmc_pkg::OFS_RESET_CTL)
      begin
        reset_bit_next = cpu_req.wdata[0];
        rd_ptr_next = bmc_pkg::PTR_RESET;
        wr_ptr_next = bmc_pkg::PTR_RESET;
        stop_next = bmc_pkg::PTR_RESET;
      end
      else if (!hold)
      begin
        if (cpu_req.addr == bmc_pkg::OFS_HOST_CTL)
          host_ctl_next = cpu_req.wdata;
        else if (cpu_req.addr == bmc_pkg::OFS_XFER_CTL)
          xfer_ctl_next = cpu_req.wdata;
        else if (cpu_req.addr == bmc_pkg::OFS_BUF_SIZE)
          buf_size_next = cpu_req.wdata;
        else if (cpu_req.addr == bmc_pkg::OFS_ADDR_MODE)
          addr_mode_next = cpu_req.wdata;
        else if (cpu_req.addr == bmc_pkg::OFS_RD_PTR_LO)
          rd_ptr_next[7:0] = cpu_req.wdata;
        else if (cpu_req.addr == bmc_pkg::OFS_RD_PTR_HI)
          rd_ptr_next[15:8] = cpu_req.wdata;
        else if (cpu_req.addr == bmc_pkg::OFS_WR_PTR_LO)
          wr_ptr_next[7:0] = cpu_req.wdata;
        else if (cpu_req.addr == bmc_pkg::OFS_WR_PTR_HI)
          wr_ptr_next[15:8] = cpu_req.wdata;
        // new stop value reopens the transfer
        else if (cpu_req.addr == bmc_pkg::OFS_STOP_LO)
          stop_next[7:0] = cpu_req.wdata;
        else if (cpu_req.addr == bmc_pkg::OFS_STOP_HI)
          stop_next[15:8] = cpu_req.wdata;
      end
    end
    // reset pin sets the hold bit
    if (!rst_n)
      reset_bit_next = 1'b1;
    if (hold)
    begin
      host_ctl_next = bmc_pkg::CTL_RESET;
      xfer_ctl_next = bmc_pkg::CTL_RESET;
      buf_size_next = bmc_pkg::CTL_RESET;
      addr_mode_next = bmc_pkg::CTL_RESET;
      rd_ptr_next = bmc_pkg::PTR_RESET;
      wr_ptr_next = bmc_pkg::PTR_RESET;
      stop_next = bmc_pkg::PTR_RESET;
    end
  end

  // Read data mux; status bits are sampled live
  always_comb
  begin
    rdata_next = rdata_reg;
    if (cpu_req.rd)
    begin
      rdata_next = 8'h00;
      if (cpu_req.addr == bmc_pkg::OFS_HOST_CTL)
      begin
        rdata_next = {host_ctl_reg[7:6], scsi_bsy_in, scsi_sel_in,
                      host_ctl_reg[3:2], 1'b0, arb_status};
      end
      else if (cpu_req.addr == bmc_pkg::OFS_XFER_CTL)
      begin
        rdata_next = {xfer_ctl_reg[7:6], done, xfer_ctl_reg[4:2], scsi_ack_in, 1'b0};
      end
      else if (cpu_req.addr == bmc_pkg::OFS_BUF_SIZE)
        rdata_next = buf_size_reg;
      else if (cpu_req.addr == bmc_pkg::OFS_ADDR_MODE)
        rdata_next = {7'h00, addr_mode_reg[0]};
      else if (cpu_req.addr == bmc_pkg::OFS_RD_PTR_LO)
        rdata_next = rd_ptr_reg[7:0];
      else if (cpu_req.addr == bmc_pkg::OFS_RD_PTR_HI)
        rdata_next = rd_ptr_reg[15:8];
      else if (cpu_req.addr == bmc_pkg::OFS_WR_PTR_LO)
        rdata_next = wr_ptr_reg[7:0];
      else if (cpu_req.addr == bmc_pkg::OFS_WR_PTR_HI)
        rdata_next = wr_ptr_reg[15:8];
      else if (cpu_req.addr == bmc_pkg::OFS_STOP_LO)
        rdata_next = stop_reg[7:0];
      else if (cpu_req.addr == bmc_pkg::OFS_STOP_HI)
        rdata_next = stop_reg[15:8];
    end
  end

  // State registers; the hold bit itself is set by the pin
  always_ff @(posedge ref_clk)
  begin
    host_ctl_reg <= host_ctl_next;
    xfer_ctl_reg <= xfer_ctl_next;
    buf_size_reg <= buf_size_next;
    addr_mode_reg <= addr_mode_next;
    reset_bit_reg <= reset_bit_next;
    rd_ptr_reg <= rd_ptr_next;
    wr_ptr_reg <= wr_ptr_next;
    stop_reg <= stop_next;
    rdata_reg <= hold ? bmc_pkg::CTL_RESET : rdata_next;
    hs_reg <= hold ? bmc_pkg::HS_IDLE : hs_next;
  end

  // Pin drives from control bits
  assign cpu_rdata = rdata_reg;
  assign arb_enable = host_ctl_reg[bmc_pkg::HC_ARB];
  assign host_inbound_enable = host_ctl_reg[bmc_pkg::HC_IN_EN];
  assign host_outbound_enable = host_ctl_reg[bmc_pkg::HC_OUT_EN];
  assign scsi_sel_out = host_ctl_reg[bmc_pkg::HC_SEL_OUT];
  assign scsi_bsy_out = host_ctl_reg[bmc_pkg::HC_BSY_OUT];
  assign initiator_enable_out_n = !xfer_ctl_reg[bmc_pkg::XC_INIT];
  assign target_enable_out_n = !xfer_ctl_reg[bmc_pkg::XC_TGT];
  assign host_req = (hs_reg == bmc_pkg::HS_REQ);
  // upper lines only in extended mode
  assign upper_addr_en = addr_mode_reg[0];
  assign upper_direct_address_lines = addr_mode_reg[0] ? active_ptr[13:10] : 4'h0;
  assign buf_addr = active_ptr;
  // Outbound disk bytes follow the strobe with direction clear; data comes from the FIFO output
  assign disk_out_valid = disk_byte_strobe && !xfer_ctl_reg[bmc_pkg::XC_DIR];
  assign disk_out_data = buf_wdata;

  // Disk bytes queue here so a slow buffer port stalls the disk side
  bmc_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_fifo (
    .clk(ref_clk),
    .clr(hold),
    .in_valid(disk_byte_strobe && xfer_ctl_reg[bmc_pkg::XC_DIR]),
    .in_ready(disk_in_ready),
    .in_data(disk_in_data),
    .out_valid(buf_wvalid),
    .out_ready(buf_wready),
    .out_data(buf_wdata)
  );
  // Checks on register behaviour
  property p_done_cmp;
    @(posedge ref_clk) disable iff (hold)
    cpu_req.rd && cpu_req.addr == bmc_pkg::OFS_XFER_CTL
      |=> cpu_rdata[bmc_pkg::XC_DONE] == $past(done);
  endproperty
  a_done_cmp: assert property (p_done_cmp) else $error("done bit wrong");
  property p_rst_clr;
    @(posedge ref_clk) disable iff (!rst_n)
    cpu_req.wr && cpu_req.addr == bmc_pkg::OFS_RESET_CTL
      |=> rd_ptr_reg == 16'h0000 && wr_ptr_reg == 16'h0000 && stop_reg == 16'h0000;
  endproperty
  a_rst_clr: assert property (p_rst_clr) else $error("pointers not cleared");
  property p_rd_step;
    @(posedge ref_clk) disable iff (hold || cpu_req.wr)
    host_step && xfer_ctl_reg[bmc_pkg::XC_DIR] |=> rd_ptr_reg == $past(rd_ptr_reg) + 16'h0001;
  endproperty
  a_rd_step: assert property (p_rd_step) else $error("read pointer not stepped");
  property p_wr_step;
    @(posedge ref_clk) disable iff (hold || cpu_req.wr)
    disk_in_take |=> wr_ptr_reg == $past(wr_ptr_reg) + 16'h0001;
  endproperty
  a_wr_step: assert property (p_wr_step) else $error("write pointer not stepped");
  property p_hold;
    @(posedge ref_clk) !rst_n |=> reset_bit_reg ##1 host_ctl_reg == 8'h00;
  endproperty
  a_hold: assert property (p_hold) else $error("hold not taken");
  property p_sel_live;
    @(posedge ref_clk) disable iff (hold)
    cpu_req.rd && cpu_req.addr == bmc_pkg::OFS_HOST_CTL
      |=> cpu_rdata[bmc_pkg::HC_SEL_IN] == $past(scsi_sel_in);
  endproperty
  a_sel_live: assert property (p_sel_live) else $error("select not live");
  property p_bsy;
    @(posedge ref_clk) disable iff (hold)
    wr_hit && cpu_req.addr == bmc_pkg::OFS_HOST_CTL |=> scsi_bsy_out == $past(cpu_req.wdata[7]);
  endproperty
  a_bsy: assert property (p_bsy) else $error("busy pin wrong");
  property p_init;
    @(posedge ref_clk) disable iff (hold)
    wr_hit && cpu_req.addr == bmc_pkg::OFS_XFER_CTL
      |=> initiator_enable_out_n == !$past(cpu_req.wdata[6]);
  endproperty
  a_init: assert property (p_init) else $error("initiator enable wrong");
endmodule

module bmc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and clear
  input wire logic clk,
  input wire logic clr,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_reg, wp_next, rp_reg, rp_next;

  // Full when pointers differ only in the wrap bit
  assign in_ready = (wp_reg ^ rp_reg) != {1'b1, {AW{1'b0}}};
  assign out_valid = wp_reg != rp_reg;
  assign out_data = mem[rp_reg[AW-1:0]];

  // Pointer next values
  always_comb
  begin
    wp_next = wp_reg + (AW+1)'(in_valid && in_ready);
    rp_next = rp_reg + (AW+1)'(out_valid && out_ready);
    if (clr)
    begin
      wp_next = '0;
      rp_next = '0;
    end
  end

  // Storage and pointers
  always_ff @(posedge clk)
  begin
    if (in_valid && in_ready)
      mem[wp_reg[AW-1:0]] <= in_data;
    wp_reg <= wp_next;
    rp_reg <= rp_next;
  end
endmodule

// ---- tb/bmc_host_model.sv ----
// Far-side host model answering the request and acknowledge handshake
`timescale 1ns/1ps
module bmc_host_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Handshake
  input wire logic host_req,
  output logic scsi_ack_in,
  // Control from the bench
  input wire logic idle_ack,
  input wire logic [1:0] lag,
  output int unsigned acks
);
  logic ack_q;
  logic [1:0] wait_q;

  // Bench may hold the line high on its own to probe the status bit
  assign scsi_ack_in = ack_q | idle_ack;

  // answer each request
  // Lag lets the host answer promptly or slowly; it never acks unasked
  always @(negedge ref_clk)
  begin
    if (!rst_n)
    begin
      ack_q <= 1'b0;
      wait_q <= 2'h0;
      acks <= 0;
    end
    else if (!ack_q && host_req)
    begin
      if (wait_q == lag)
      begin
        ack_q <= 1'b1;
        wait_q <= 2'h0;
      end
      else
        wait_q <= wait_q + 2'h1;
    end
    else if (ack_q && !host_req)
    begin
      ack_q <= 1'b0;
      acks <= acks + 1;
    end
  end
endmodule

// ---- tb/test_buffer_manager_control_registers.sv ----
// Self-checking bench for the buffer manager control register block
`timescale 1ns/1ps
module test_buffer_manager_control_registers;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [3:0] live;
    logic [7:0] mask;
    logic [7:0] rexp;
    logic [6:0] pins;
  } bmc_row_s;
  // Live inputs are {select, busy, ack, arbitration status}
  localparam bmc_row_s ROWS [0:11] = '{
    '{8'h52, 8'h8C, 4'h9, 8'hFD, 8'h9D, 7'h1F}, '{8'h52, 8'h41, 4'h4, 8'hFD, 8'h60, 7'h63},
    '{8'h53, 8'hC0, 4'h2, 8'hFE, 8'hE2, 7'h60}, '{8'h54, 8'hFF, 4'h0, 8'hFF, 8'hFF, 7'h60},
    '{8'h55, 8'h01, 4'h0, 8'h01, 8'h01, 7'h60}, '{8'h5A, 8'h34, 4'h0, 8'hFF, 8'h34, 7'h60},
    '{8'h5B, 8'h12, 4'h0, 8'hFF, 8'h12, 7'h60}, '{8'h5C, 8'h78, 4'h0, 8'hFF, 8'h78, 7'h60},
    '{8'h5D, 8'h56, 4'h0, 8'hFF, 8'h56, 7'h60}, '{8'h5E, 8'hBC, 4'h0, 8'hFF, 8'hBC, 7'h60},
    '{8'h5F, 8'h9A, 4'h0, 8'hFF, 8'h9A, 7'h60}, '{8'h60, 8'h5A, 4'h0, 8'hFF, 8'h00, 7'h60}};
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  bmc_pkg::bmc_req_s cpu_req = '0;
  logic [7:0] cpu_rdata, buf_wdata, disk_out_data;
  logic sel_in = 1'b0, bsy_in = 1'b0, ack_lvl = 1'b0, arb_st = 1'b0, ack;
  logic arb_en, sel_o, bsy_o, in_en, out_en, ei_n, et_n, host_req, upper_en;
  logic [3:0] upper;
  logic [15:0] buf_addr;
  logic strobe = 1'b0, buf_wready = 1'b0, disk_in_ready, disk_out_valid, buf_wvalid;
  logic [7:0] din = 8'h00;
  logic [1:0] lag = 2'h0;
  logic [6:0] pins;
  int unsigned acks;
  int error_cnt = 0, comparisons = 0, cycles = 0, acc, n;

  assign pins = {arb_en, sel_o, bsy_o, in_en, out_en, ei_n, et_n};

  // Free running clock, 8 ns period
  always #4 ref_clk = ~ref_clk;

  bmc_top u_bmc_top (.ref_clk(ref_clk), .rst_n(rst_n), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
    .scsi_sel_in(sel_in), .scsi_bsy_in(bsy_in), .scsi_ack_in(ack), .arb_status(arb_st),
    .arb_enable(arb_en), .scsi_sel_out(sel_o), .scsi_bsy_out(bsy_o),
    .host_inbound_enable(in_en), .host_outbound_enable(out_en),
    .initiator_enable_out_n(ei_n), .target_enable_out_n(et_n), .host_req(host_req),
    .upper_direct_address_lines(upper), .upper_addr_en(upper_en), .buf_addr(buf_addr),
    .disk_byte_strobe(strobe), .disk_in_data(din), .disk_in_ready(disk_in_ready),
    .disk_out_data(disk_out_data), .disk_out_valid(disk_out_valid),
    .buf_wdata(buf_wdata), .buf_wvalid(buf_wvalid), .buf_wready(buf_wready));

  bmc_host_model u_bmc_host_model (.ref_clk(ref_clk), .rst_n(rst_n), .host_req(host_req),
    .scsi_ack_in(ack), .idle_ack(ack_lvl), .lag(lag), .acks(acks));

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle strobes; an idle cycle always separates two requests
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    cpu_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge ref_clk);
    cpu_req.wr = 1'b0;
  endtask

  // Data is sampled one and a half cycles after the taking edge, where it stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    cpu_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge ref_clk);
    cpu_req.rd = 1'b0;
    @(negedge ref_clk);
    d = cpu_rdata;
  endtask

  // Undefined bits are masked away before comparing
  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    check("cpu_rdata", 16'(e), 16'(d & m));
  endtask

  // Poll the done bit under a bound, then count finished handshakes
  task automatic poll(input int unsigned want);
    logic [7:0] d;
    int k;
    d = 8'h00;
    k = 0;
    while (d[5] !== 1'b1 && k < 200)
    begin
      rd(bmc_pkg::OFS_XFER_CTL, d);
      k++;
    end
    check("dma_done", 16'h1, 16'(d[5]));
    check("handshakes", 16'(want), 16'(acks));
    check("host_req", 16'h0, 16'(host_req));
  endtask

  task automatic conclude;
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Cut a hang short well above the expected few hundred cycles
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      conclude();
    end
  end

  initial
  begin
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    check("pins", 16'h03, 16'(pins));
    wr(bmc_pkg::OFS_RESET_CTL, 8'h00);
    foreach (ROWS[i])
    begin
      {sel_in, bsy_in, ack_lvl, arb_st} = ROWS[i].live;
      wr(ROWS[i].addr, ROWS[i].wdata);
      rdc(ROWS[i].addr, ROWS[i].mask, ROWS[i].rexp);
      check("pins", 16'(ROWS[i].pins), 16'(pins));
    end
    check("upper_lines", 16'h5, 16'(upper));
    check("buf_addr", 16'h5678, buf_addr);
    check("upper_en", 16'h1, 16'(upper_en));
    // Hold bit set by a write, then a clearing write
    wr(bmc_pkg::OFS_RESET_CTL, 8'h01);
    // The hold bit is registered, so fields clear one cycle after the write
    @(negedge ref_clk);
    check("pins", 16'h03, 16'(pins));
    wr(bmc_pkg::OFS_RESET_CTL, 8'h00);
    rdc(8'h5B, 8'hFF, 8'h00);
    rdc(8'h5D, 8'hFF, 8'h00);
    rdc(8'h5F, 8'hFF, 8'h00);
    // Zero both high bytes so outside address latches start clean
    wr(8'h5B, 8'h00);
    wr(8'h5D, 8'h00);
    rdc(8'h55, 8'h01, 8'h00);
    check("upper_en", 16'h0, 16'(upper_en));
    // Disk fills the FIFO while the buffer side stalls
    wr(bmc_pkg::OFS_XFER_CTL, 8'h10);
    acc = 0;
    repeat (34)
    begin
      strobe = 1'b1;
      din = 8'(acc);
      if (disk_in_ready === 1'b1)
        acc++;
      @(negedge ref_clk);
    end
    check("disk_out_valid", 16'h0, 16'(disk_out_valid));
    strobe = 1'b0;
    check("accepted", 16'd32, 16'(acc));
    check("disk_in_ready", 16'h0, 16'(disk_in_ready));
    rdc(8'h5C, 8'hFF, 8'h20);
    buf_wready = 1'b1;
    n = 0;
    repeat (40)
    begin
      if (buf_wvalid === 1'b1)
      begin
        check("buf_wdata", 16'(n), 16'(buf_wdata));
        check("disk_out_data", 16'(n), 16'(disk_out_data));
        n++;
      end
      @(negedge ref_clk);
    end
    check("drained", 16'd32, 16'(n));
    check("buf_wvalid", 16'h0, 16'(buf_wvalid));
    // Single block read: stop at write pointer minus one, slow host
    wr(8'h5E, 8'h1F);
    lag = 2'h2;
    wr(bmc_pkg::OFS_XFER_CTL, 8'h18);
    poll(31);
    rdc(8'h5A, 8'hFF, 8'h1F);
    wr(8'h5E, 8'h21);
    poll(33);
    rdc(8'h5A, 8'hFF, 8'h21);
    // Write direction: strobe goes outward, host fills the buffer
    wr(bmc_pkg::OFS_XFER_CTL, 8'h00);
    strobe = 1'b1;
    @(negedge ref_clk);
    check("disk_out_valid", 16'h1, 16'(disk_out_valid));
    strobe = 1'b0;
    wr(8'h5E, 8'h24);
    lag = 2'h0;
    wr(bmc_pkg::OFS_XFER_CTL, 8'h04);
    poll(37);
    rdc(8'h5C, 8'hFF, 8'h24);
    // Pin reset in mid-run sets the hold bit again
    wr(bmc_pkg::OFS_HOST_CTL, 8'h84);
    rst_n = 1'b0;
    @(negedge ref_clk);
    rst_n = 1'b1;
    check("pins", 16'h03, 16'(pins));
    rdc(8'h5C, 8'hFF, 8'h00);
    conclude();
  end
endmodule
